// ===== hw/meas_flow_consts.vh
// Constants for the measurement command flow of the sensor signal conditioner.
`ifndef MEAS_FLOW_CONSTS_VH
`define MEAS_FLOW_CONSTS_VH

// ********************************************
// Command codes
// ********************************************
`define CMD_MEAS_CYCLIC    8'hAB
`define CMD_HALT_CYCLIC    8'hBF
`define CMD_MEAS_RAW       8'hA0
`define CMD_MEAS_COND      8'hA1
`define CMD_STATUS         8'hF0

// ********************************************
// Register offsets and reset values
// ********************************************
`define REG_INTF_CONFIG    8'h02
`define REG_SENS_CONFIG0   8'h03
`define REG_SENS_CONFIG1   8'h04
`define REG_CAL_OFFSET     8'h05
`define RST_INTF_CONFIG    16'h0000
`define RST_SENS_CONFIG    16'h0000
`define RST_CAL_OFFSET     16'h0000

// ********************************************
// Field positions
// ********************************************
`define IC_CFG_SEL_BIT     0
`define IC_COND_BIT        1
`define IC_PAUSE_LSB       2
`define IC_PAUSE_MSB       5
`define STAT_BUSY_BIT      5
`define STAT_COND_BIT      3

// ********************************************
// Timing
// ********************************************
`define CONV_TIME_MS       30
`define CLK_MHZ            250
`define PAUSE_UNIT_CYC     16'h0100

`endif

// ===== hw/sensor_measurement_command_flow.v
// Measurement sequencer: single and cyclic measurements, status byte and result registers.
`timescale 1ns/10ps
`include "meas_flow_consts.vh"

module sensor_measurement_command_flow (
  input  wire        clk_i,          // 250 MHz system clock
  input  wire        reset_n_i,      // Synchronous reset, active low
  input  wire        cmd_valid_i,    // Command strobe, one cycle
  input  wire [7:0]  cmd_code_i,     // Command code
  input  wire        reg_wr_i,       // Register write strobe, one cycle
  input  wire [7:0]  reg_addr_i,     // Register offset for write and read
  input  wire [15:0] reg_wdata_i,    // Register write data
  output reg  [15:0] reg_rdata_o,    // Register read data, registered
  input  wire        adc_done_i,     // ADC conversion finished, one cycle
  input  wire [23:0] adc_data_i,     // ADC result, valid with adc_done_i
  output wire        adc_start_o,    // Starts one ADC phase, one cycle
  output reg  [1:0]  adc_phase_o,    // Phase being converted
  output reg  [15:0] adc_config_o,   // Sensor setup used by the ADC
  output reg  [23:0] sensor_res_o,   // Sensor result register
  output reg  [23:0] temp_res_o,     // Temperature result register
  output reg  [7:0]  status_o,       // Status byte, latched on request
  output wire        status_valid_o  // Status byte answer strobe
);

  // ********************************************
  // States and phases
  // ********************************************
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_WAIT  = 3'd2;
  localparam [2:0] ST_PAUSE = 3'd3;
  localparam [1:0] PH_SAZ   = 2'd0;   // sensor_autozero_phase
  localparam [1:0] PH_SM    = 2'd1;   // sensor_measure_phase
  localparam [1:0] PH_TAZ   = 2'd2;   // temp_autozero_phase
  localparam [1:0] PH_TM    = 2'd3;   // temp_measure_phase

  reg [15:0] intf_config_r;
  reg [15:0] sens_config0_r;
  reg [15:0] sens_config1_r;
  reg [15:0] cal_offset_r;
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [1:0]  phase_r;
  reg        cyclic_r;
  reg        cond_r;
  reg [15:0] pause_r;
  reg [23:0] saz_r;
  reg [23:0] taz_r;
  reg        stat_req_r;

  // Busy is derived from the sequencer state, which returns to IDLE only at the end
  // of a single cycle or on the halt command.
  // busy through pauses
  wire busy = (state_r != ST_IDLE);
  wire cmd_cyc  = cmd_valid_i && (cmd_code_i == `CMD_MEAS_CYCLIC);
  wire cmd_halt = cmd_valid_i && (cmd_code_i == `CMD_HALT_CYCLIC);
  wire cmd_raw  = cmd_valid_i && (cmd_code_i == `CMD_MEAS_RAW);
  wire cmd_cond = cmd_valid_i && (cmd_code_i == `CMD_MEAS_COND);
  wire cmd_stat = cmd_valid_i && (cmd_code_i == `CMD_STATUS);
  wire cmd_go   = !busy && (cmd_cyc || cmd_raw || cmd_cond);
  wire [15:0] pause_len = {12'h000, intf_config_r[`IC_PAUSE_MSB:`IC_PAUSE_LSB]} * `PAUSE_UNIT_CYC;

  assign adc_start_o    = (state_r == ST_START);
  assign status_valid_o = stat_req_r;

  // Autozero-corrected value; for the sensor result, conditioning adds the calibration offset with saturation.
  function [23:0] correct;
    input [23:0] raw;
    input [23:0] zero;
    input        cond;
    input [15:0] offs;
    reg   [24:0] sum;
    begin
      sum = {1'b0, raw - zero};
      if (cond)
      begin
        sum = sum + {{9{offs[15]}}, offs};
        if (sum[24] && !offs[15])
          sum = 25'h0FFFFFF;
        else if (sum[24])
          sum = 25'h0000000;
      end
      correct = sum[23:0];
    end
  endfunction

  // ********************************************
  // Register file
  // ********************************************
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      intf_config_r  <= `RST_INTF_CONFIG;
      sens_config0_r <= `RST_SENS_CONFIG;
      sens_config1_r <= `RST_SENS_CONFIG;
      cal_offset_r   <= `RST_CAL_OFFSET;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `REG_INTF_CONFIG)
        intf_config_r <= reg_wdata_i;
      if (reg_addr_i == `REG_SENS_CONFIG0)
        sens_config0_r <= reg_wdata_i;
      if (reg_addr_i == `REG_SENS_CONFIG1)
        sens_config1_r <= reg_wdata_i;
      if (reg_addr_i == `REG_CAL_OFFSET)
        cal_offset_r <= reg_wdata_i;
    end
  end

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= 16'h0000;
    else
      case (reg_addr_i)
        `REG_INTF_CONFIG:  reg_rdata_o <= intf_config_r;
        `REG_SENS_CONFIG0: reg_rdata_o <= sens_config0_r;
        `REG_SENS_CONFIG1: reg_rdata_o <= sens_config1_r;
        `REG_CAL_OFFSET:   reg_rdata_o <= cal_offset_r;
        default:           reg_rdata_o <= 16'h0000;
      endcase
  end

  // ********************************************
  // Sequencer
  // ********************************************
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (cmd_go)
          state_nxt = ST_START;
      ST_START:
        state_nxt = ST_WAIT;
      ST_WAIT:
        if (adc_done_i && phase_r == PH_TM)
          state_nxt = cyclic_r ? ST_PAUSE : ST_IDLE;
        else if (adc_done_i)
          state_nxt = ST_START;
      ST_PAUSE:
        if (pause_r == 16'h0000)
          state_nxt = ST_START;
      default:
        state_nxt = ST_IDLE;
    endcase
    if (cmd_halt)
      state_nxt = ST_IDLE;
  end

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_r      <= ST_IDLE;
      phase_r      <= PH_SAZ;
      cyclic_r     <= 1'b0;
      cond_r       <= 1'b0;
      pause_r      <= 16'h0000;
      adc_phase_o  <= PH_SAZ;
      adc_config_o <= `RST_SENS_CONFIG;
      saz_r        <= 24'h000000;
      taz_r        <= 24'h000000;
      sensor_res_o <= 24'h000000;
      temp_res_o   <= 24'h000000;
    end
    else
    begin
      state_r <= state_nxt;
      if (cmd_go)
      begin
        phase_r  <= PH_SAZ;
        cyclic_r <= cmd_cyc;
        cond_r   <= cmd_cyc ? intf_config_r[`IC_COND_BIT] : cmd_cond;
        adc_config_o <= intf_config_r[`IC_CFG_SEL_BIT] ? sens_config1_r : sens_config0_r;
      end
      if (state_r == ST_START)
        adc_phase_o <= phase_r;
      if (state_r == ST_WAIT && adc_done_i)
      begin
        phase_r <= phase_r + 2'd1;
        if (phase_r == PH_SAZ)
          saz_r <= adc_data_i;
        if (phase_r == PH_TAZ)
          taz_r <= adc_data_i;
        if (phase_r == PH_SM)
          sensor_res_o <= cond_r ? correct(adc_data_i, saz_r, 1'b1, cal_offset_r)
                                 : adc_data_i;
        if (phase_r == PH_TM)
          temp_res_o <= cond_r ? correct(adc_data_i, taz_r, 1'b0, cal_offset_r)
                               : adc_data_i;
        if (phase_r == PH_TM)
          pause_r <= pause_len;
      end
      else if (state_r == ST_PAUSE && pause_r != 16'h0000)
        pause_r <= pause_r - 16'h0001;
    end
  end

  // ********************************************
  // Status byte
  // ********************************************
  // The byte is latched on the request so the host sees one consistent snapshot.
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      stat_req_r <= 1'b0;
      status_o   <= 8'h00;
    end
    else
    begin
      stat_req_r <= cmd_stat;
      if (cmd_stat)
      begin
        status_o <= 8'h00;
        status_o[`STAT_BUSY_BIT] <= busy;
        status_o[`STAT_COND_BIT] <= cond_r;
      end
    end
  end

endmodule

// ===== verification/adc_model.sv
// Converter model answering each phase start after a fixed delay.
`timescale 1ns/10ps
module adc_model #(
  parameter int DLY = 20
) (
  input  wire logic       clk_i,          // Clock
  input  wire logic       start_i,        // Phase start
  input  wire logic [1:0] phase_i,        // Phase
  output logic            done_o = 1'b0,  // Phase done
  output logic [23:0]     data_o = '0     // Result
);
  logic [7:0] cnt = 8'h00;
  // Data toggles outside the done cycle so a late sample never matches by luck.
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (start_i)
      cnt <= 8'(DLY);
    else if (cnt != 8'h00)
    begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01)
      begin
        done_o <= 1'b1;
        data_o <= 24'h000111 * ({22'h000000, phase_i} + 24'h000001);
      end
    end
  end
endmodule

// ===== verification/meas_flow_monitor.sv
// Port checks for the measurement sequencer.
`timescale 1ns/10ps
module meas_flow_monitor (
  input wire logic       clk_i,          // Clock
  input wire logic       reset_n_i,      // Reset, active low
  input wire logic       cmd_valid_i,    // Command strobe
  input wire logic [7:0] cmd_code_i,     // Command code
  input wire logic       adc_done_i,     // Phase done
  input wire logic       adc_start_o,    // Phase start
  input wire logic [1:0] adc_phase_o,    // Phase
  input wire logic [7:0] status_o,       // Status byte
  input wire logic       status_valid_o  // Status strobe
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // A halt leaves the converter finishing a phase; its late done must not count.
  logic live_r = 1'b0;
  always @(posedge clk_i)
  begin
    if (!reset_n_i || (cmd_valid_i && cmd_code_i == 8'hBF))
      live_r <= 1'b0;
    else if (adc_start_o)
      live_r <= 1'b1;
  end
  sequence ask_s;
    cmd_valid_i && cmd_code_i == 8'hF0;
  endsequence
  sequence halt_s;
    cmd_valid_i && cmd_code_i == 8'hBF;
  endsequence
  a_status_answer: assert property (ask_s |=> status_valid_o)
    else $error("status not answered");
  a_status_lone: assert property (!cmd_valid_i |=> !status_valid_o)
    else $error("status strobe without request");
  a_status_spare: assert property (status_valid_o |-> (status_o & 8'hD7) == 8'h00)
    else $error("spare status bits set");
  a_start_pulse: assert property (adc_start_o |=> !adc_start_o)
    else $error("start longer than one cycle");
  a_phase_order: assert property (live_r && adc_done_i && !cmd_valid_i && adc_phase_o != 2'd3
    |=> adc_start_o ##1 adc_phase_o == $past(adc_phase_o, 2) + 2'd1)
    else $error("phase order broken");
  a_halt_idle: assert property (halt_s |=> !adc_start_o)
    else $error("start after halt");
  a_halt_clear: assert property (halt_s ##1 !cmd_valid_i ##1 ask_s |=> !status_o[5])
    else $error("busy after halt");
  a_busy_running: assert property (adc_start_o ##1 ask_s |=> status_o[5])
    else $error("idle while converting");
endmodule
bind sensor_measurement_command_flow meas_flow_monitor u_mon (.*);

// ===== verification/sensor_measurement_command_flow_tb.sv
// Self-checking bench for the measurement sequencer.
`timescale 1ns/10ps
module sensor_measurement_command_flow_tb;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  logic [7:0]  cmd_code_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o, adc_config_o;
  logic        adc_done_i, adc_start_o, status_valid_o;
  logic [23:0] adc_data_i, sensor_res_o, temp_res_o;
  logic [1:0]  adc_phase_o;
  logic [7:0]  status_o;
  int          fail_count = 0;
  int          checks = 0;
  int          starts = 0;
  int          s0;
  sensor_measurement_command_flow DUT (.*);
  adc_model #(.DLY(20)) u_adc (.clk_i(clk_i), .start_i(adc_start_o), .phase_i(adc_phase_o),
    .done_o(adc_done_i), .data_o(adc_data_i));
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (adc_start_o === 1'b1) starts <= starts + 1;
  task chk(input string n, input logic [23:0] s, input logic [23:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task cmd(input logic [7:0] c);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_code_i <= c;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    @(posedge clk_i);
    #1 chk("reg", {8'h00, reg_rdata_o}, {8'h00, e});
  endtask
  task stat;
    cmd(8'hF0);
    #1 chk("answer", {23'h0, status_valid_o}, 24'h1);
  endtask
  task busy(input logic e);
    chk("busy", {23'h0, status_o[5]}, {23'h0, e});
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    fail_count++;
    conclude;
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(8'h02, 16'h0000);
    rd(8'h7F, 16'h0000);
    wr(8'h03, 16'h1234);
    wr(8'h04, 16'h5678);
    wr(8'h05, 16'h0005);
    rd(8'h04, 16'h5678);
    cmd(8'hA0);
    stat;
    busy(1'b1);
    repeat (100) @(posedge clk_i);
    stat;
    busy(1'b0);
    chk("stat", {16'h0000, status_o}, 24'h000000);
    chk("raw s", sensor_res_o, 24'h000222);
    chk("raw t", temp_res_o, 24'h000444);
    chk("cfg", {8'h00, adc_config_o}, 24'h001234);
    cmd(8'hA1);
    do stat; while (status_o[5] !== 1'b0);
    chk("cond s", sensor_res_o, 24'h000116);
    chk("cond t", temp_res_o, 24'h000111);
    chk("stat", {16'h0000, status_o}, 24'h000008);
    wr(8'h02, 16'h0007);
    s0 = starts;
    cmd(8'hAB);
    repeat (600) @(posedge clk_i);
    chk("again", {23'h0, (starts - s0) > 4}, 24'h1);
    stat;
    busy(1'b1);
    chk("stat", {16'h0000, status_o}, 24'h000028);
    chk("cyc s", sensor_res_o, 24'h000116);
    chk("cyc cfg", {8'h00, adc_config_o}, 24'h005678);
    cmd(8'hBF);
    stat;
    busy(1'b0);
    chk("stat", {16'h0000, status_o}, 24'h000008);
    s0 = starts;
    repeat (300) @(posedge clk_i);
    chk("halted", 24'(starts - s0), 24'h0);
    conclude;
  end
endmodule
